// file: hw/popc_map.vh
`ifndef POPC_MAP_VH
`define POPC_MAP_VH

// Register indices; byte address is four times the index
`define POPC_IDX_SYSTEM_CONTROL      6'h03
`define POPC_IDX_SYSTEM_FAULT_STATUS 6'h0C
`define POPC_IDX_POWER_OUTPUT        6'h04
`define POPC_IDX_INTERRUPT_FLAG      6'h05

// Decoded register selects
`define POPC_SEL_NONE 3'h0
`define POPC_SEL_CTL  3'h1
`define POPC_SEL_STAT 3'h2
`define POPC_SEL_POUT 3'h3
`define POPC_SEL_IFR  3'h4

// system_control fields
`define POPC_CTL_PSE      7
`define POPC_CTL_SLEW_HI  6
`define POPC_CTL_SLEW_LO  5
`define POPC_CTL_STOP     0

// system_fault_status fields
`define POPC_ST_HALL_OC   7
`define POPC_ST_LIN_CL    6
`define POPC_ST_SUP_OC    5
`define POPC_ST_LAMP_OC   4
`define POPC_ST_UV        3
`define POPC_ST_OV        2
`define POPC_ST_BRIDGE_OC 1
`define POPC_ST_OT        0

// power_output fields
`define POPC_PO_HT_RESET_EN 7
`define POPC_PO_SUPPLY_ON   1
`define POPC_PO_LAMP_ON     0

// Reset values
`define POPC_RST_BYTE 8'h00

// Synchronised input positions
`define POPC_IN_UV      0
`define POPC_IN_OV      1
`define POPC_IN_OT_WARN 2
`define POPC_IN_OT_LIM  3
`define POPC_IN_LAMP_OC 4
`define POPC_IN_SUP_OC  5
`define POPC_IN_HALL_OC 6
`define POPC_IN_BR_OC   7
`define POPC_IN_LIN_CL  8
`define POPC_IN_CHOP    9
`define POPC_IN_COUNT   10

// AXI responses
`define POPC_RESP_OKAY   2'h0
`define POPC_RESP_SLVERR 2'h2

`endif

// file: hw/popc_ctrl.v
`include "popc_map.vh"

// Function
// R01 - Voltage flags disable lamp switch output
// R02 - Write one or reset clears voltage flags
// R03 - Overtemp warning flag; limit resets, kills outputs (code resets and cuts only while power_output bit 7 is set)
// R04 - Lamp overcurrent cuts output, sets flag
// R05 - Chop clock rising edge re-enables lamp
// R06 - Lamp overcurrent flag write-one-to-clear
// R07 - Software times lamp flag to spot faults
// R08 - Supply output needs stage enable and bit
// R09 - Voltage flags never touch supply output
// R10 - Supply thermal cut only with reset enabled
// R11 - Supply overcurrent cuts output, W1C flag
// R12 - Stage enable bit seven gates power outputs
// R13 - Two-bit LIN slew select encoding
// R14 - Stop request write-only, cleared by interrupt
// R15 - Hall overcurrent flag, write-one-to-clear
// R16 - LIN current limit status read-only
// R17 - Status voltage/temp bits mirror interrupt flags
// R18 - Bridge overcurrent flag, write-one-to-clear
// R19 - Lamp needs stage enable and its bit
// R20 - Outside supplies chop clock, 0.1-20 kHz
// R21 - Synchronise fault inputs and chop clock
module popc_ctrl #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,                 // System clock, 20 MHz
  input  wire              aresetn,              // Synchronous reset, active low
  input  wire [ADDR_W-1:0] s_axi_awaddr,         // Write address
  input  wire              s_axi_awvalid,        // Write address valid
  output reg               s_axi_awready,        // Write address ready
  input  wire [31:0]       s_axi_wdata,          // Write data
  input  wire [3:0]        s_axi_wstrb,          // Write byte enables
  input  wire              s_axi_wvalid,         // Write data valid
  output reg               s_axi_wready,         // Write data ready
  output reg  [1:0]        s_axi_bresp,          // Write response
  output reg               s_axi_bvalid,         // Write response valid
  input  wire              s_axi_bready,         // Write response ready
  input  wire [ADDR_W-1:0] s_axi_araddr,         // Read address
  input  wire              s_axi_arvalid,        // Read address valid
  output reg               s_axi_arready,        // Read address ready
  output reg  [31:0]       s_axi_rdata,          // Read data
  output reg  [1:0]        s_axi_rresp,          // Read response
  output reg               s_axi_rvalid,         // Read data valid
  input  wire              s_axi_rready,         // Read data ready
  input  wire              undervolt_indication, // Low-voltage comparator pin
  input  wire              overvolt_indication,  // High-voltage comparator pin
  input  wire              overtemp_warn_in,     // Overtemperature prewarning pin
  input  wire              overtemp_limit_in,    // Overtemperature limit pin
  input  wire              lamp_oc_in,           // Lamp switch overcurrent pin
  input  wire              supply_oc_in,         // Switched supply overcurrent pin
  input  wire              hall_oc_in,           // Hall input overcurrent pin
  input  wire              bridge_oc_in,         // H-bridge overcurrent pin
  input  wire              lin_cl_in,            // LIN transmitter current limit pin
  input  wire              chop_clock_in,        // Chopping clock pin
  input  wire              cpu_irq,              // CPU interrupt request, same clock
  output reg               lamp_switch_out,      // Lamp high-side switch on
  output reg               switched_supply_out,  // Switched supply output on
  output reg               bridge_enable,        // Half-bridge drivers allowed
  output reg               hall_supply_enable,   // Hall input supply allowed
  output reg               lin_tx_enable,        // LIN transmitter allowed
  output reg               analog_src_enable,    // Analog input current sources allowed
  output reg  [1:0]        lin_slew_sel,         // LIN slew rate select
  output reg               stop_request,         // Enter STOP mode
  output reg               thermal_reset         // Overtemperature system reset
);

  // Address decode, shared by read and write paths
  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    begin
      reg_sel = `POPC_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
        case (addr[7:2])
          `POPC_IDX_SYSTEM_CONTROL:      reg_sel = `POPC_SEL_CTL;
          `POPC_IDX_SYSTEM_FAULT_STATUS: reg_sel = `POPC_SEL_STAT;
          `POPC_IDX_POWER_OUTPUT:        reg_sel = `POPC_SEL_POUT;
          `POPC_IDX_INTERRUPT_FLAG:      reg_sel = `POPC_SEL_IFR;
          default:                       reg_sel = `POPC_SEL_NONE;
        endcase
      end
    end
  endfunction

  // Pin synchronisers: three stages, a change counts once stages two and three agree
  reg  [`POPC_IN_COUNT-1:0] sync1;
  reg  [`POPC_IN_COUNT-1:0] sync2;
  reg  [`POPC_IN_COUNT-1:0] sync3;
  reg  [`POPC_IN_COUNT-1:0] filt;
  wire [`POPC_IN_COUNT-1:0] pins = {chop_clock_in, lin_cl_in, bridge_oc_in, hall_oc_in,
                                    supply_oc_in, lamp_oc_in, overtemp_limit_in,
                                    overtemp_warn_in, overvolt_indication, undervolt_indication};
  genvar gi;
  generate
    for (gi = 0; gi < `POPC_IN_COUNT; gi = gi + 1) begin : g_sync
      always @(posedge aclk) begin
        if (!aresetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          filt[gi]  <= 1'b0;
        end else begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin // see R21
            filt[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate
  reg  chop_prev;
  wire chop_rise = filt[`POPC_IN_CHOP] & ~chop_prev; // see R21
  // Write channel holding
  reg              aw_full;
  reg              w_full;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0]       w_data;
  reg [3:0]        w_strb;
  wire             wr_do   = aw_full & w_full & ~s_axi_bvalid;
  wire [2:0]       wr_sel  = reg_sel(aw_addr);
  wire [7:0]       wd      = w_data[7:0];
  wire             wr_lane = wr_do & w_strb[0];
  wire wr_ctl  = wr_lane & (wr_sel == `POPC_SEL_CTL);
  wire wr_stat = wr_lane & (wr_sel == `POPC_SEL_STAT);
  wire wr_pout = wr_lane & (wr_sel == `POPC_SEL_POUT);
  wire wr_ifr  = wr_lane & (wr_sel == `POPC_SEL_IFR);
  // Software-written state
  reg       power_stage_enable;
  reg       lin_slew_sel_hi;
  reg       lin_slew_sel_lo;
  reg       lamp_switch_on;
  reg       switched_supply_on;
  reg       ht_reset_enable;
  // Sticky flags
  reg       undervolt_flag;
  reg       overvolt_flag;
  reg       overtemp_flag;
  reg       lamp_switch_overcurrent_flag;
  reg       switched_supply_overcurrent_flag;
  reg       hall_pin_overcurrent_flag;
  reg       bridge_overcurrent_flag;
  reg       lamp_cut;
  wire      voltage_fault = undervolt_flag | overvolt_flag;
  wire      thermal_kill  = ht_reset_enable & filt[`POPC_IN_OT_LIM]; // see R03 R10

  always @(posedge aclk) begin
    if (!aresetn) begin
      power_stage_enable <= 1'b0; // see R12
      lin_slew_sel_hi    <= 1'b0;
      lin_slew_sel_lo    <= 1'b0;
      lamp_switch_on     <= 1'b0;
      switched_supply_on <= 1'b0;
      ht_reset_enable    <= 1'b0;
      stop_request       <= 1'b0;
    end else begin
      if (wr_ctl) begin
        power_stage_enable <= wd[`POPC_CTL_PSE]; // see R12
        lin_slew_sel_hi    <= wd[`POPC_CTL_SLEW_HI]; // see R13
        lin_slew_sel_lo    <= wd[`POPC_CTL_SLEW_LO];
      end
      if (wr_pout) begin
        lamp_switch_on     <= wd[`POPC_PO_LAMP_ON];
        switched_supply_on <= wd[`POPC_PO_SUPPLY_ON];
        ht_reset_enable    <= wd[`POPC_PO_HT_RESET_EN];
      end
      // A request written with an interrupt in the same cycle still goes through
      if (wr_ctl && wd[`POPC_CTL_STOP]) begin
        stop_request <= 1'b1; // see R14
      end else if (cpu_irq) begin
        stop_request <= 1'b0; // see R14
      end
    end
  end

  // Flags: hardware set wins over a write-one clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      undervolt_flag                   <= 1'b0; // see R02
      overvolt_flag                    <= 1'b0;
      overtemp_flag                    <= 1'b0;
      lamp_switch_overcurrent_flag     <= 1'b0; // see R06
      switched_supply_overcurrent_flag <= 1'b0; // see R11
      hall_pin_overcurrent_flag        <= 1'b0; // see R15
      bridge_overcurrent_flag          <= 1'b0; // see R18
      lamp_cut                         <= 1'b0;
      chop_prev                        <= 1'b0;
    end else begin
      chop_prev <= filt[`POPC_IN_CHOP];
      // Clearing is futile while the condition persists
      if (filt[`POPC_IN_UV]) begin
        undervolt_flag <= 1'b1; // see R02
      end else if (wr_ifr && wd[`POPC_ST_UV]) begin
        undervolt_flag <= 1'b0; // see R02
      end
      if (filt[`POPC_IN_OV]) begin
        overvolt_flag <= 1'b1;
      end else if (wr_ifr && wd[`POPC_ST_OV]) begin
        overvolt_flag <= 1'b0; // see R02
      end
      if (filt[`POPC_IN_OT_WARN]) begin
        overtemp_flag <= 1'b1; // see R03
      end else if (wr_ifr && wd[`POPC_ST_OT]) begin
        overtemp_flag <= 1'b0;
      end
      if (filt[`POPC_IN_LAMP_OC]) begin
        lamp_switch_overcurrent_flag <= 1'b1; // see R04
      end else if (wr_stat && wd[`POPC_ST_LAMP_OC]) begin
        lamp_switch_overcurrent_flag <= 1'b0; // see R06
      end
      if (filt[`POPC_IN_SUP_OC]) begin
        switched_supply_overcurrent_flag <= 1'b1; // see R11
      end else if (wr_stat && wd[`POPC_ST_SUP_OC]) begin
        switched_supply_overcurrent_flag <= 1'b0; // see R11
      end
      if (filt[`POPC_IN_HALL_OC]) begin
        hall_pin_overcurrent_flag <= 1'b1; // see R15
      end else if (wr_stat && wd[`POPC_ST_HALL_OC]) begin
        hall_pin_overcurrent_flag <= 1'b0; // see R15
      end
      if (filt[`POPC_IN_BR_OC]) begin
        bridge_overcurrent_flag <= 1'b1; // see R18
      end else if (wr_stat && wd[`POPC_ST_BRIDGE_OC]) begin
        bridge_overcurrent_flag <= 1'b0; // see R18
      end
      // Cut is separate from the flag so chopping can retry while the flag stays up
      if (filt[`POPC_IN_LAMP_OC]) begin
        lamp_cut <= 1'b1; // see R04
      end else if (chop_rise) begin
        lamp_cut <= 1'b0; // see R05
      end else if (wr_stat && wd[`POPC_ST_LAMP_OC]) begin
        lamp_cut <= 1'b0; // see R06
      end
    end
  end

  // Output drivers, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      lamp_switch_out     <= 1'b0;
      switched_supply_out <= 1'b0;
      bridge_enable       <= 1'b0;
      hall_supply_enable  <= 1'b0;
      lin_tx_enable       <= 1'b0;
      analog_src_enable   <= 1'b0;
      lin_slew_sel        <= 2'h0;
      thermal_reset       <= 1'b0;
    end else begin
      lamp_switch_out     <= power_stage_enable & lamp_switch_on & ~voltage_fault
                             & ~lamp_cut & ~thermal_kill; // see R01 R19 R04 R03
      // Voltage flags deliberately absent here
      switched_supply_out <= power_stage_enable & switched_supply_on
                             & ~switched_supply_overcurrent_flag
                             & ~thermal_kill; // see R08 R09 R10 R11
      bridge_enable       <= power_stage_enable & ~voltage_fault
                             & ~bridge_overcurrent_flag & ~thermal_kill; // see R12 R18
      hall_supply_enable  <= ~hall_pin_overcurrent_flag; // see R15
      lin_tx_enable       <= power_stage_enable & ~thermal_kill; // see R12
      analog_src_enable   <= power_stage_enable & ~thermal_kill; // see R12
      lin_slew_sel        <= {lin_slew_sel_hi, lin_slew_sel_lo}; // see R13
      thermal_reset       <= thermal_kill; // see R03
    end
  end
  // Read data assembly
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = `POPC_RST_BYTE;
    case (reg_sel(s_axi_araddr))
      `POPC_SEL_CTL: begin
        rd_byte[`POPC_CTL_PSE]     = power_stage_enable;
        rd_byte[`POPC_CTL_SLEW_HI] = lin_slew_sel_hi;
        rd_byte[`POPC_CTL_SLEW_LO] = lin_slew_sel_lo;
      end
      `POPC_SEL_STAT: begin
        rd_byte[`POPC_ST_HALL_OC]   = hall_pin_overcurrent_flag;
        rd_byte[`POPC_ST_LIN_CL]    = filt[`POPC_IN_LIN_CL]; // see R16
        rd_byte[`POPC_ST_SUP_OC]    = switched_supply_overcurrent_flag;
        rd_byte[`POPC_ST_LAMP_OC]   = lamp_switch_overcurrent_flag;
        rd_byte[`POPC_ST_UV]        = undervolt_flag; // see R17
        rd_byte[`POPC_ST_OV]        = overvolt_flag; // see R17
        rd_byte[`POPC_ST_BRIDGE_OC] = bridge_overcurrent_flag;
        rd_byte[`POPC_ST_OT]        = overtemp_flag; // see R17
      end
      `POPC_SEL_POUT: begin
        rd_byte[`POPC_PO_HT_RESET_EN] = ht_reset_enable;
        rd_byte[`POPC_PO_SUPPLY_ON]   = switched_supply_on;
        rd_byte[`POPC_PO_LAMP_ON]     = lamp_switch_on;
      end
      `POPC_SEL_IFR: begin
        rd_byte[`POPC_ST_UV] = undervolt_flag;
        rd_byte[`POPC_ST_OV] = overvolt_flag;
        rd_byte[`POPC_ST_OT] = overtemp_flag;
      end
      default: rd_byte = `POPC_RST_BYTE;
    endcase
  end

  // AXI4-Lite write path: address and data taken in either order, one at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `POPC_RESP_OKAY;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      if (!aw_full && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (!w_full && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == `POPC_SEL_NONE) ? `POPC_RESP_SLVERR : `POPC_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `POPC_RESP_OKAY;
    end else begin
      if (!s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_byte};
        s_axi_rresp   <= (reg_sel(s_axi_araddr) == `POPC_SEL_NONE) ?
                         `POPC_RESP_SLVERR : `POPC_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // popc_ctrl

// file: tb/popc_cpu.sv
module popc_cpu (
  input  wire logic        aclk,    // Clock
  output logic       [7:0] awaddr,  // Write address
  output logic             awvalid, // Address valid
  input  wire logic        awready, // Address taken
  output logic      [31:0] wdata,   // Write data
  output logic             wvalid,  // Data valid
  input  wire logic        wready,  // Data taken
  input  wire logic  [1:0] bresp,   // Write response
  input  wire logic        bvalid,  // Response valid
  output logic       [7:0] araddr,  // Read address
  output logic             arvalid, // Address valid
  input  wire logic        arready, // Address taken
  input  wire logic [31:0] rdata,   // Read data
  input  wire logic  [1:0] rresp,   // Read response
  input  wire logic        rvalid   // Read valid
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'h0;
    wdata = 32'h0;
    wvalid = 1'h0;
    araddr = 8'h00;
    arvalid = 1'h0;
  end

  // Response readies are held high by the bench, so no release race here
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ta;
    bit td;
    ta = 0;
    td = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (!ta && awready) begin
        ta = 1;
        awvalid <= 1'h0;
      end
      if (!td && wready) begin
        td = 1;
        wvalid <= 1'h0;
      end
    end while (!(ta && td && bvalid));
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit t;
    t = 0;
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (!t && arready) begin
        t = 1;
        arvalid <= 1'h0;
      end
    end while (!(t && rvalid));
    d = rdata;
    r = rresp;
  endtask
endmodule // popc_cpu

// file: tb/popc_checker.sv
module popc_checker (
  input wire       aclk,                 // Clock
  input wire       aresetn,              // Reset, active low
  input wire       s_axi_bvalid,         // Write response valid
  input wire       s_axi_awready,        // Write address ready
  input wire       undervolt_indication, // Low-voltage pin
  input wire       supply_oc_in,         // Supply overcurrent pin
  input wire       hall_oc_in,           // Hall overcurrent pin
  input wire       bridge_oc_in,         // Bridge overcurrent pin
  input wire       cpu_irq,              // CPU interrupt
  input wire       lamp_switch_out,      // Lamp on
  input wire       switched_supply_out,  // Supply on
  input wire       bridge_enable,        // Bridges allowed
  input wire       hall_supply_enable,   // Hall supply allowed
  input wire       lin_tx_enable,        // LIN driver allowed
  input wire [1:0] lin_slew_sel,         // Slew select
  input wire       stop_request,         // STOP request
  input wire       thermal_reset         // Thermal reset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lamp_needs_stage: assert property (
    lamp_switch_out |-> lin_tx_enable) else $error("lamp on without stage enable");
  a_supply_needs_stage: assert property (
    switched_supply_out |-> lin_tx_enable) else $error("supply on without stage enable");
  a_thermal_kills_all: assert property (
    thermal_reset |-> !lamp_switch_out && !switched_supply_out && !bridge_enable
    && !lin_tx_enable) else $error("power output on during thermal reset");
  a_undervolt_cuts_lamp: assert property (
    undervolt_indication [*8] |-> !lamp_switch_out) else $error("lamp on at undervoltage");
  a_supply_oc_cut: assert property (
    supply_oc_in [*8] |-> !switched_supply_out) else $error("supply on at overcurrent");
  a_hall_oc_cut: assert property (
    hall_oc_in [*8] |-> !hall_supply_enable) else $error("hall supply on at overcurrent");
  a_bridge_oc_cut: assert property (
    bridge_oc_in [*8] |-> !bridge_enable) else $error("bridge on at overcurrent");
  // A write already taken may set the bit again later, so only idle bus counts
  a_stop_irq_clear: assert property (
    cpu_irq && s_axi_awready |-> ##[1:2] !stop_request) else $error("stop kept after irq");
  a_slew_on_write: assert property (
    $changed(lin_slew_sel) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("slew changed without a write");
endmodule // popc_checker

bind popc_ctrl popc_checker popc_checker_i (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_awready, .undervolt_indication, .supply_oc_in,
  .hall_oc_in, .bridge_oc_in, .cpu_irq, .lamp_switch_out, .switched_supply_out, .bridge_enable,
  .hall_supply_enable, .lin_tx_enable, .lin_slew_sel, .stop_request, .thermal_reset);

// file: tb/tb_top.sv
`include "popc_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ctl = {`POPC_IDX_SYSTEM_CONTROL, 2'h0};
  localparam logic [7:0] stat = {`POPC_IDX_SYSTEM_FAULT_STATUS, 2'h0};
  localparam logic [7:0] pout = {`POPC_IDX_POWER_OUTPUT, 2'h0};
  localparam logic [7:0] flag_reg = {`POPC_IDX_INTERRUPT_FLAG, 2'h0};
  localparam logic [31:0] all_regs = {ctl, stat, pout, flag_reg};
  localparam logic [1:0] ok = `POPC_RESP_OKAY;
  localparam logic [1:0] err = `POPC_RESP_SLVERR;
  logic        aclk, aresetn, cpu_irq, s_axi_bready, s_axi_rready;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, stop_request, thermal_reset;
  logic        lamp_switch_out, switched_supply_out, bridge_enable, hall_supply_enable;
  logic        lin_tx_enable, analog_src_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lin_slew_sel;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [9:0]  pin;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          fail_count, compares, cycles;

  popc_ctrl popc_ctrl_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .undervolt_indication(pin[`POPC_IN_UV]), .overvolt_indication(pin[`POPC_IN_OV]),
    .overtemp_warn_in(pin[`POPC_IN_OT_WARN]), .overtemp_limit_in(pin[`POPC_IN_OT_LIM]),
    .lamp_oc_in(pin[`POPC_IN_LAMP_OC]), .supply_oc_in(pin[`POPC_IN_SUP_OC]),
    .hall_oc_in(pin[`POPC_IN_HALL_OC]), .bridge_oc_in(pin[`POPC_IN_BR_OC]),
    .lin_cl_in(pin[`POPC_IN_LIN_CL]), .chop_clock_in(pin[`POPC_IN_CHOP]), .cpu_irq,
    .lamp_switch_out, .switched_supply_out, .bridge_enable, .hall_supply_enable, .lin_tx_enable,
    .analog_src_enable, .lin_slew_sel, .stop_request, .thermal_reset);

  popc_cpu popc_cpu_i (
    .aclk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .wdata(s_axi_wdata), .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid), .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
    .arready(s_axi_arready), .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid));

  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Compares %0d, errors %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Values are read just after an edge, so they are the settled pre-edge ones
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    popc_cpu_i.wr(a, d, r);
    chk(r, er);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    popc_cpu_i.rd(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask

  // Long enough to pass the pin filter and set the flag
  task automatic pulse(input int i);
    pin[i] <= 1'h1;
    cyc(6);
    pin[i] <= 1'h0;
    cyc(8);
  endtask

  initial begin
    aresetn = 1'h0;
    cpu_irq = 1'h0;
    pin = 10'h000;
    s_axi_bready = 1'h1;
    s_axi_rready = 1'h1;
    s_axi_wstrb = 4'hF;
    cyc(6);
    aresetn <= 1'h1;
    cyc(1);
    for (int i = 0; i < 4; i++) rc(all_regs[31-8*i -: 8], 0, ok);
    rc(8'h40, 0, err);
    rc(8'h0D, 0, err);
    wc(8'h40, 32'hFF, err);
    for (int s = 0; s < 4; s++) begin
      wc(ctl, 32'h80 | (s << 5), ok);
      cyc(2);
      chk(lin_slew_sel, s);
      rc(ctl, 32'h80 | (s << 5), ok);
    end
    s_axi_wstrb <= 4'hE;
    wc(ctl, 32'h0, ok);
    s_axi_wstrb <= 4'hF;
    rc(ctl, 32'hE0, ok);
    wc(ctl, 32'h80, ok);
    wc(pout, 32'h3, ok);
    cyc(3);
    chk({lamp_switch_out, switched_supply_out, lin_tx_enable, analog_src_enable}, 4'hF);
    for (int i = 0; i < 2; i++) begin
      pin[`POPC_IN_UV + i] <= 1'h1;
      cyc(8);
      chk({lamp_switch_out, switched_supply_out}, 2'h1);
      rc(stat, 32'h8 >> i, ok);
      rc(flag_reg, 32'h8 >> i, ok);
      wc(flag_reg, 32'h8 >> i, ok);
      rc(flag_reg, 32'h8 >> i, ok);
      pin[`POPC_IN_UV + i] <= 1'h0;
      cyc(8);
      wc(flag_reg, 32'h0, ok);
      cyc(3);
      chk(lamp_switch_out, 1'h0);
      wc(flag_reg, 32'h8 >> i, ok);
      cyc(3);
      chk(lamp_switch_out, 1'h1);
    end
    pulse(`POPC_IN_LAMP_OC);
    chk(lamp_switch_out, 1'h0);
    pin[`POPC_IN_CHOP] <= 1'h1;
    cyc(8);
    chk(lamp_switch_out, 1'h1);
    rc(stat, 32'h10, ok);
    pin[`POPC_IN_CHOP] <= 1'h0;
    wc(stat, 32'h0, ok);
    rc(stat, 32'h10, ok);
    wc(stat, 32'h10, ok);
    rc(stat, 32'h0, ok);
    for (int i = 0; i < 3; i++) begin
      pulse(`POPC_IN_SUP_OC + i);
      chk({bridge_enable, hall_supply_enable, switched_supply_out}, 3'h7 ^ (3'h1 << i));
      rc(stat, i == 0 ? 32'h20 : i == 1 ? 32'h80 : 32'h02, ok);
      wc(stat, 32'hA2, ok);
      cyc(3);
      chk({bridge_enable, hall_supply_enable, switched_supply_out}, 3'h7);
    end
    pin[`POPC_IN_LIN_CL] <= 1'h1;
    cyc(8);
    rc(stat, 32'h40, ok);
    pin[`POPC_IN_LIN_CL] <= 1'h0;
    cyc(8);
    rc(stat, 32'h0, ok);
    pin[`POPC_IN_OT_WARN] <= 1'h1;
    cyc(8);
    rc(flag_reg, 32'h1, ok);
    rc(stat, 32'h1, ok);
    pin[`POPC_IN_OT_LIM] <= 1'h1;
    cyc(8);
    chk({thermal_reset, switched_supply_out}, 2'h1);
    wc(pout, 32'h83, ok);
    cyc(3);
    chk({thermal_reset, lamp_switch_out, switched_supply_out, bridge_enable}, 4'h8);
    pin <= 10'h000;
    cyc(8);
    wc(ctl, 32'h81, ok);
    cyc(2);
    chk(stop_request, 1'h1);
    rc(ctl, 32'h80, ok);
    cpu_irq <= 1'h1;
    cyc(1);
    cpu_irq <= 1'h0;
    cyc(2);
    chk(stop_request, 1'h0);
    wc(ctl, 32'h0, ok);
    cyc(3);
    chk({lamp_switch_out, switched_supply_out, lin_tx_enable, analog_src_enable}, 4'h0);
    give_verdict();
  end
endmodule // tb_top
